// ---- hw/wwsu_pkg.sv ----
// Constants for the watchdog status upper-half block
// Summary of operation
// RULE1: Last bad event survives system reset
// RULE2: Write 111 clears last event before reset
// RULE3: After reset output, clear needs bus reset
// RULE4: Event codes: 0 none, 1, 2, 3
// RULE5: Fail count resets to five
// RULE6: Good event decrements, floor at zero
// RULE7: Bad event increments, saturates at seven
// RULE8: Bad event at seven raises reset
// RULE9: Pending flag sets when sequence timer starts
// RULE10: Write one clears pending flag and pin
// RULE11: Pending flag warns reset at rollover
// RULE12: Interrupt flag sets cycle after point; the code sets it two cycles after, via hit_reg
// RULE13: Timer restart clears interrupt flag
// RULE14: Write one clears interrupt flag and pin
// RULE15: Kick outside second window is bad
// RULE16: Wrong config or reset clears enable
// RULE17: Reserved bits read zero, writes ignored
package wwsu_pkg;
    localparam logic [7:0] WWSU_ESR_OFFSET  = 8'h10; // Enable and status
    localparam int         WWSU_LBE_LSB     = 24;    // Last bad event field
    localparam int         WWSU_FCV_LSB     = 20;    // Fail count field
    localparam int         WWSU_WRP_BIT     = 17;    // Reset pending flag
    localparam int         WWSU_WINDOW_INTERRUPT_FLAG_BIT    = 16;    // Window interrupt flag
    localparam int         WWSU_WSW_BIT     = 8;     // Second window flag
    localparam logic [2:0] WWSU_FCV_RESET   = 3'h5;  // Fail count at reset
    localparam logic [2:0] WWSU_FCV_MAX     = 3'h7;  // Fail count ceiling
    localparam logic [2:0] WWSU_LBE_CLEAR   = 3'h7;  // Clear pattern
    localparam logic [2:0] WWSU_EV_NONE     = 3'h0;  // No bad event
    localparam logic [2:0] WWSU_EV_FIRST    = 3'h1;  // First window kick
    localparam logic [2:0] WWSU_EV_SIG      = 3'h2;  // Signature / disable
    localparam logic [2:0] WWSU_EV_OVERFLOW = 3'h3;  // Second window overflow
endpackage

// ---- hw/wwsu_fail_counter.sv ----
// Saturating three-bit fail counter driven by good and bad events
`timescale 1ns/1ps
module wwsu_fail_counter
    import wwsu_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_good,
    input  wire logic       i_bad,
    output logic      [2:0] o_count,
    output logic            o_at_max
);
    logic [2:0] count_reg;  // Current fail count
    logic [2:0] count_next; // Next fail count
    wire        is_zero = (count_reg == 3'h0);
    wire        is_max  = (count_reg == WWSU_FCV_MAX);

    // Bad wins when both arrive: a fault must never be masked by a kick
    assign count_next = i_bad  ? (is_max  ? count_reg : count_reg + 3'h1) // RULE7
                      : i_good ? (is_zero ? count_reg : count_reg - 3'h1) // RULE6
                      : count_reg;

    // Count register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= WWSU_FCV_RESET; // RULE5
        end else begin
            count_reg <= count_next;
        end
    end

    assign o_count  = count_reg;
    assign o_at_max = is_max;
endmodule

// ---- hw/wwsu_status_upper.sv ----
// Upper status fields of the windowed watchdog enable-and-status register
`timescale 1ns/1ps
module wwsu_status_upper
    import wwsu_pkg::*;
(
    input  wire logic        i_clk,          // 40 MHz bus clock
    input  wire logic        i_rst_n,        // Bus reset
    input  wire logic        i_por_n,        // Power-on reset only
    input  wire logic        i_wr_en,        // Register write strobe
    input  wire logic  [7:0] i_wr_addr,      // Write byte offset
    input  wire logic [31:0] i_wr_data,      // Write data
    input  wire logic        i_rd_en,        // Register read strobe
    input  wire logic  [7:0] i_rd_addr,      // Read byte offset
    output logic      [31:0] o_rd_data,      // Read data, one cycle later
    input  wire logic        i_good_event,   // Good event from window logic
    input  wire logic        i_bad_event,    // Bad event from window logic
    input  wire logic  [2:0] i_bad_code,     // Code of that bad event
    input  wire logic        i_fc_enable,    // Fail counter enabled
    input  wire logic        i_sst_enable,   // Sequence timer in use
    input  wire logic        i_sst_rollover, // Sequence timer rolled over
    input  wire logic        i_in_second_win,// Second window flag state
    input  wire logic        i_intr_point,   // Count at interrupt point
    input  wire logic        i_restart,      // Timer restart
    input  wire logic        i_cfg_wrong,    // Wrong configuration seen
    output logic             o_sst_start,    // Start sequence timer, pulse
    output logic             o_wdt_reset,    // Watchdog reset
    output logic             o_wdt_reset_pending,
    output logic             o_wdt_interrupt,
    output logic             o_bad_write,    // Early kick seen, pulse
    output logic             o_win_enable_clr // Force window enable low
);
    logic  [2:0] lbe_reg;     // Last bad event, power-on reset only
    logic  [2:0] lbe_next;
    logic        lock_reg;    // Reset output has been raised
    logic        wrp_reg;     // Reset pending flag
    logic        wrp_next;
    logic        window_interrupt_flag_reg;    // Window interrupt flag
    logic        window_interrupt_flag_next;
    logic        hit_reg;     // Interrupt point seen last cycle
    logic        rst_reg;     // Reset output register
    logic        sst_reg;     // Sequence timer start pulse register
    logic        bad_wr_reg;  // Early kick pulse register
    logic [31:0] rd_reg;      // Read data register
    logic  [2:0] fail_count_value;         // Fail count
    logic        fcv_max;     // Fail count at ceiling

    // Address decode
    wire esr_wr = i_wr_en && (i_wr_addr == WWSU_ESR_OFFSET);
    wire esr_rd = i_rd_en && (i_rd_addr == WWSU_ESR_OFFSET);

    // Write strobes: 111 clear, write-one clears and the kick; reserved bits are simply not looked at
    wire wr_lbe_clr  = esr_wr && (i_wr_data[WWSU_LBE_LSB +: 3]
                                  == WWSU_LBE_CLEAR);
    wire wr_wrp_clr  = esr_wr && i_wr_data[WWSU_WRP_BIT];  // RULE10
    wire wr_window_interrupt_flag_clr = esr_wr && i_wr_data[WWSU_WINDOW_INTERRUPT_FLAG_BIT]; // RULE14
    wire wr_wsw_one  = esr_wr && i_wr_data[WWSU_WSW_BIT];

    // Kick written while not in second window is a bad event
    wire early_kick = wr_wsw_one && !i_in_second_win; // RULE15

    // All bad events, early kick coded as a first-window fault
    wire       bad_any  = i_bad_event || early_kick;
    wire [2:0] bad_code = i_bad_event ? i_bad_code : WWSU_EV_FIRST; // RULE4

    // Fault that ends the watchdog: counter full, or no counter at all
    wire fatal     = bad_any && (!i_fc_enable || fcv_max); // RULE8
    wire fatal_now = fatal && !i_sst_enable && !rst_reg;
    wire sst_go    = fatal && i_sst_enable && !wrp_reg && !rst_reg;

    // Next value of the last bad event; a new event beats the clear
    assign lbe_next = bad_any ? bad_code
                    : (wr_lbe_clr && !lock_reg) ? WWSU_EV_NONE // RULE2 RULE3
                    : lbe_reg;

    // Pending flag: start sets, write one clears, set wins
    assign wrp_next = sst_go ? 1'b1 // RULE9
                    : wr_wrp_clr ? 1'b0 // RULE10
                    : wrp_reg;

    // Interrupt flag set two cycles after the point, via hit_reg; set wins over clears
    assign window_interrupt_flag_next = hit_reg ? 1'b1 // RULE12
                     : (i_restart || wr_window_interrupt_flag_clr) ? 1'b0 // RULE13 RULE14
                     : window_interrupt_flag_reg;

    // Fail counter follows events only while it is enabled
    wwsu_fail_counter u_fc (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_good   (i_good_event && i_fc_enable), // RULE6
        .i_bad    (bad_any && i_fc_enable),      // RULE7
        .o_count  (fail_count_value),
        .o_at_max (fcv_max)
    );

    // Last bad event lives on power-on reset so a bus reset keeps it
    always_ff @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            lbe_reg <= WWSU_EV_NONE;
        end else begin
            lbe_reg <= lbe_next; // RULE1
        end
    end

    // Lock is released by bus reset, so a 111 write after it clears
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lock_reg <= 1'b0;
        end else if (fatal_now
                     || (i_sst_rollover && (wrp_reg || sst_reg))) begin
            lock_reg <= 1'b1; // RULE3
        end
    end

    // Reset output holds until bus reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_reg <= 1'b0;
        end else if (fatal_now) begin
            rst_reg <= 1'b1; // RULE8
        end else if (i_sst_rollover && (wrp_reg || sst_reg)) begin
            rst_reg <= 1'b1; // RULE11
        end
    end

    // Status flags and one-cycle pulses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wrp_reg    <= 1'b0;
            window_interrupt_flag_reg   <= 1'b0;
            hit_reg    <= 1'b0;
            sst_reg    <= 1'b0;
            bad_wr_reg <= 1'b0;
        end else begin
            wrp_reg    <= wrp_next;
            window_interrupt_flag_reg   <= window_interrupt_flag_next;
            hit_reg    <= i_intr_point;
            sst_reg    <= sst_go;
            bad_wr_reg <= early_kick;
        end
    end

    // Read data registered; unmapped offsets and reserved bits read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_reg <= 32'h0000_0000;
        end else if (esr_rd) begin
            rd_reg <= {5'h00, lbe_reg, 1'b0, fail_count_value, 2'h0, wrp_reg, // RULE17
                       window_interrupt_flag_reg, 7'h00, i_in_second_win, 8'h00};
        end else if (i_rd_en) begin
            rd_reg <= 32'h0000_0000;
        end
    end

    // Outputs; the sequence timer is only told to start, it runs outside
    assign o_rd_data           = rd_reg;
    assign o_sst_start         = sst_reg;
    assign o_wdt_reset         = rst_reg;
    assign o_wdt_reset_pending = wrp_reg; // RULE11
    assign o_wdt_interrupt     = window_interrupt_flag_reg;
    assign o_bad_write         = bad_wr_reg;
    // Enable dropped on bad setup or reset, beyond write protection
    assign o_win_enable_clr    = i_cfg_wrong || rst_reg; // RULE16
endmodule

// ---- dv/wwsu_status_upper_properties.sv ----
// Property checker for the watchdog status upper block
`timescale 1ns/1ps
module wwsu_status_upper_chk
    import wwsu_pkg::*;
(
    input wire logic        i_clk, i_rst_n, i_wr_en, i_bad_event,
    input wire logic        i_sst_rollover, i_in_second_win, i_intr_point,
    input wire logic        i_restart, i_cfg_wrong, o_sst_start, o_wdt_reset,
    input wire logic        o_wdt_reset_pending, o_wdt_interrupt, o_bad_write,
    input wire logic        o_win_enable_clr,
    input wire logic  [7:0] i_wr_addr,
    input wire logic [31:0] i_wr_data, o_rd_data
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Write aimed at the status word
    wire wr_esr = i_wr_en && (i_wr_addr == WWSU_ESR_OFFSET);
    a_pend_set: assert property (
        o_sst_start |-> o_wdt_reset_pending) else $error("pending not set");
    a_pend_clear: assert property (
        wr_esr && i_wr_data[17] && !i_bad_event |=> !o_wdt_reset_pending)
        else $error("pending not cleared");
    a_int_set: assert property (
        i_intr_point |=> ##1 o_wdt_interrupt) else $error("no interrupt");
    a_int_clear: assert property (
        (i_restart || (wr_esr && i_wr_data[16])) && !i_intr_point
        && !$past(i_intr_point) |=> !o_wdt_interrupt)
        else $error("interrupt not cleared");
    a_reset_hold: assert property (
        o_wdt_reset |=> o_wdt_reset) else $error("reset dropped");
    a_reset_cause: assert property (
        $rose(o_wdt_reset)
        |-> $past(i_bad_event || i_sst_rollover || i_wr_en))
        else $error("reset without cause");
    a_en_clear: assert property (
        o_win_enable_clr == (i_cfg_wrong || o_wdt_reset))
        else $error("enable clear wrong");
    a_bad_kick: assert property (
        wr_esr && i_wr_data[8] && !i_in_second_win |=> o_bad_write)
        else $error("early kick missed");
    a_rsvd_zero: assert property (
        (o_rd_data & 32'hf88c_feff) == 32'h0) else $error("reserved set");
endmodule
bind wwsu_status_upper wwsu_status_upper_chk chk_inst (
    .i_clk, .i_rst_n, .i_wr_en, .i_bad_event, .i_sst_rollover,
    .i_in_second_win, .i_intr_point, .i_restart, .i_cfg_wrong, .o_sst_start,
    .o_wdt_reset, .o_wdt_reset_pending, .o_wdt_interrupt, .o_bad_write,
    .o_win_enable_clr, .i_wr_addr, .i_wr_data, .o_rd_data);

// ---- dv/wwsu_host.sv ----
// Host model issuing register strobes on the bus clock
`timescale 1ns/1ps
module wwsu_host (
    input  wire logic        i_clk,
    output logic             o_wr_en = 1'b0,
    output logic             o_rd_en = 1'b0,
    output logic       [7:0] o_addr  = 8'h0,
    output logic      [31:0] o_data  = 32'h0
);
    // One strobe, held until its taking edge; data then shows junk
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge i_clk);
        o_wr_en <= w;
        o_rd_en <= !w;
        o_addr  <= a;
        o_data  <= d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_data  <= ~d;
    endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the watchdog status upper block
`timescale 1ns/1ps
module tb;
    import wwsu_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0; // Clock, resets
    logic  [4:0] ev = 5'h0;   // Roll, intr, restart, bad, good
    logic  [2:0] bc = 3'h1;   // Code sent with bad events
    logic  [2:0] l = 3'h0;    // Last bad code, expected in reads
    logic        sste = 1'b0, isw = 1'b0, cfg = 1'b0, rd_d = 1'b0;
    logic        fce = 1'b1;  // Fail counter enable level
    logic        we, re, sst_s, rst_o, pend, intr, bw, enc;
    logic  [7:0] ad;
    logic [31:0] wd, rdat, seed = 32'h3a81;
    logic [31:0] q[$];        // Expected read words, oldest first
    int          n_fail = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    wwsu_host wwsu_host_inst (.i_clk(clk), .o_wr_en(we), .o_rd_en(re),
        .o_addr(ad), .o_data(wd));
    wwsu_status_upper wwsu_status_upper_inst (.i_clk(clk), .i_rst_n(rst_n),
        .i_por_n(por_n), .i_wr_en(we), .i_wr_addr(ad), .i_wr_data(wd),
        .i_rd_en(re), .i_rd_addr(ad), .o_rd_data(rdat),
        .i_good_event(ev[0]), .i_bad_event(ev[1]), .i_bad_code(bc),
        .i_fc_enable(fce), .i_sst_enable(sste), .i_sst_rollover(ev[4]),
        .i_in_second_win(isw), .i_intr_point(ev[3]), .i_restart(ev[2]),
        .i_cfg_wrong(cfg), .o_sst_start(sst_s), .o_wdt_reset(rst_o),
        .o_wdt_reset_pending(pend), .o_wdt_interrupt(intr),
        .o_bad_write(bw), .o_win_enable_clr(enc));
    // Expected status word from its fields
    function automatic logic [31:0] wrd(input logic [2:0] e, f,
                                        input logic p, i, s);
        return {5'h0, e, 1'b0, f, 2'h0, p, i, 7'h0, s, 8'h0};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wwsu_host_inst.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [31:0] d);
        wwsu_host_inst.xfer(1'b1, WWSU_ESR_OFFSET, d);
        @(negedge clk);
    endtask
    // One-cycle event; random code kept in 1..3 so it stays legal
    task automatic pulse(input int b);
        seed = xs(seed);
        @(posedge clk);
        ev[b] <= 1'b1;
        bc    <= 3'(seed % 3) + 3'h1;
        if (b == 1) l = 3'(seed % 3) + 3'h1;
        @(posedge clk);
        ev[b] <= 1'b0;
        @(negedge clk);
    endtask
    // Bus reset only; power-on reset stays released
    task automatic bus_rst(input logic s);
        @(posedge clk);
        rst_n <= 1'b0;
        sste  <= s;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
    endtask
    // Read words are checked one cycle after the taking edge
    always @(posedge clk) begin
        rd_d <= re;
        if (rd_d) chk(rdat, q.pop_front());
    end
    // Hang guard
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rdx(8'h10, wrd(3'h0, WWSU_FCV_RESET, 0, 0, 0));
        repeat (6) pulse(0);
        rdx(8'h10, wrd(3'h0, 3'h0, 0, 0, 0));
        repeat (7) pulse(1);
        rdx(8'h10, wrd(l, WWSU_FCV_MAX, 0, 0, 0));
        wr(32'h0700_0000);
        rdx(8'h10, wrd(3'h0, 3'h7, 0, 0, 0));
        pulse(1);
        chk(32'(rst_o & enc), 32'h1);
        wr(32'h0700_0000);
        rdx(8'h10, wrd(l, 3'h7, 0, 0, 0));
        bus_rst(1'b1);
        rdx(8'h10, wrd(l, 3'h5, 0, 0, 0));
        wr(32'h0700_0000);
        rdx(8'h10, wrd(3'h0, 3'h5, 0, 0, 0));
        repeat (3) pulse(1);
        chk(32'({sst_s, pend, rst_o}), 32'h6);
        rdx(8'h10, wrd(l, 3'h7, 1, 0, 0));
        wr(32'h0002_0000);
        chk(32'(pend), 32'h0);
        pulse(1);
        pulse(4);
        chk(32'(rst_o), 32'h1);
        bus_rst(1'b1);
        pulse(3);
        @(negedge clk);
        chk(32'(intr), 32'h1);
        rdx(8'h10, wrd(l, 3'h5, 0, 1, 0));
        wr(32'h0001_0000);
        chk(32'(intr), 32'h0);
        pulse(3);
        pulse(2);
        chk(32'(intr), 32'h0);
        wr(32'h0000_0100);
        chk(32'(bw), 32'h1);
        wwsu_host_inst.xfer(1'b1, 8'h14, 32'hffff_ffff);
        rdx(8'h14, 32'h0);
        @(posedge clk);
        isw <= 1'b1;
        cfg <= 1'b1;
        rdx(8'h10, wrd(3'h1, 3'h6, 0, 0, 1));
        @(negedge clk);
        chk(32'(enc), 32'h1);
        @(posedge clk);
        fce <= 1'b0;
        pulse(0);
        rdx(8'h10, wrd(3'h1, 3'h6, 0, 0, 1));
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule
